// *** hdl/windowed_watchdog_supervisor.sv ***
// Supervisor: stretched system reset plus a windowed watchdog with a fault pulse.
// Assumes supply flag and pins are asynchronous to clock; outputs are push-pull levels.
`timescale 1ns/100ps
`include "wdog_supervisor_map.svh"
module windowed_watchdog_supervisor
  import wdog_supervisor_pkg::*;
#(
  parameter option_t OPTION = 3'h0,
  parameter int RESET_STRETCH_CYC = `RESET_STRETCH_CYC,
  parameter int FAULT_PULSE_CYC = `FAULT_PULSE_CYC,
  parameter int CYC_PER_US = `CYC_PER_US
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Supervised inputs.
  input wire logic supplyLow,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  // Outputs.
  output logic systemReset_n,
  output logic watchdog_fault_pulse_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Option lookup, all eight windows kept so any build picks one.

  function automatic window_s windowOf(input option_t opt, input int cpu);
    window_s w;
    w = '0;
    unique case (opt)
      3'h0: w = '{win_cnt_t'(`FAST_US_A * cpu), win_cnt_t'(`SLOW_US_A * cpu)};
      3'h1: w = '{win_cnt_t'(`FAST_US_B * cpu), win_cnt_t'(`SLOW_US_B * cpu)};
      3'h2: w = '{win_cnt_t'(`FAST_US_C * cpu), win_cnt_t'(`SLOW_US_C * cpu)};
      3'h3: w = '{win_cnt_t'(`FAST_US_D * cpu), win_cnt_t'(`SLOW_US_D * cpu)};
      3'h4: w = '{win_cnt_t'(`FAST_US_E * cpu), win_cnt_t'(`SLOW_US_E * cpu)};
      3'h5: w = '{win_cnt_t'(`FAST_US_F * cpu), win_cnt_t'(`SLOW_US_F * cpu)};
      3'h6: w = '{win_cnt_t'(`FAST_US_G * cpu), win_cnt_t'(`SLOW_US_G * cpu)};
      3'h7: w = '{win_cnt_t'(`FAST_US_H * cpu), win_cnt_t'(`SLOW_US_H * cpu)};
    endcase
    return w;
  endfunction

  localparam window_s WIN = windowOf(OPTION, CYC_PER_US);
  localparam int KICK_MIN_CYC = `KICK_MIN_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops, nothing reads the first.

  logic [2:0] sync1_ff, sync2_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 3'h3;
      sync2_ff <= 3'h3;
    end else begin
      sync1_ff <= {supplyLow, manual_reset_n, watchdog_kick_in};
      sync2_ff <= sync1_ff;
    end
  end
  logic supLow, mrN, kick;
  assign supLow = sync2_ff[2];
  assign mrN = sync2_ff[1];
  assign kick = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Kick qualifier: a high phase must last the least pulse width before its
  // falling edge counts, which also rejects short glitches.

  logic [3:0] highCnt_ff, nxt_highCnt;
  logic kickPrev_ff, nxt_kickPrev;
  logic kickEdge;
  always_comb begin
    nxt_kickPrev = kick;
    nxt_highCnt = highCnt_ff;
    if (!kick) begin
      nxt_highCnt = 4'h0;
    end else if (highCnt_ff < 4'(KICK_MIN_CYC)) begin
      nxt_highCnt = highCnt_ff + 4'h1;
    end
    kickEdge = kickPrev_ff && !kick && (highCnt_ff >= 4'(KICK_MIN_CYC));
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      kickPrev_ff <= 1'b0;
      highCnt_ff <= 4'h0;
    end else begin
      kickPrev_ff <= nxt_kickPrev;
      highCnt_ff <= nxt_highCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System reset with stretch.

  logic [31:0] rstCnt_ff, nxt_rstCnt;
  logic sysRstN_ff, nxt_sysRstN;
  always_comb begin
    nxt_rstCnt = rstCnt_ff;
    nxt_sysRstN = sysRstN_ff;
    if (supLow || !mrN) begin
      nxt_rstCnt = 32'h0;
      nxt_sysRstN = 1'b0;
    end else if (!sysRstN_ff) begin
      if (rstCnt_ff >= 32'(RESET_STRETCH_CYC - 1)) begin
        nxt_sysRstN = 1'b1;
      end else begin
        nxt_rstCnt = rstCnt_ff + 32'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rstCnt_ff <= 32'h0;
      sysRstN_ff <= 1'b0;
    end else begin
      rstCnt_ff <= nxt_rstCnt;
      sysRstN_ff <= nxt_sysRstN;
    end
  end
  // Output comes straight from its flop so it never glitches on a decode.
  assign systemReset_n = sysRstN_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Windowed watchdog. The timer runs while the system reset is held too;
  // the manual reset clears it, matching the pin's documented effect, and so does the release of the system reset.

  wd_state_e state_ff, nxt_state;
  win_cnt_t winCnt_ff, nxt_winCnt;
  logic [31:0] pulseCnt_ff, nxt_pulseCnt;
  logic sysRstPrev_ff;
  logic fault;
  always_comb begin
    nxt_state = state_ff;
    nxt_winCnt = (winCnt_ff == '1) ? winCnt_ff : winCnt_ff + win_cnt_t'(1);
    nxt_pulseCnt = pulseCnt_ff;
    fault = 1'b0;
    unique case (state_ff)
      WD_FIRST, WD_ARMED: begin
        if (kickEdge) begin
          nxt_winCnt = '0;
          nxt_state = WD_ARMED;
          // The first edge after a release is exempt from the fast check.
          if (state_ff == WD_ARMED && winCnt_ff < WIN.fastCyc) begin
            fault = 1'b1;
          end
        end else if (winCnt_ff >= WIN.slowCyc - win_cnt_t'(1)) begin
          fault = 1'b1;
        end
        if (fault) begin
          nxt_state = WD_FAULT;
          nxt_pulseCnt = 32'h0;
        end
      end
      WD_FAULT: begin
        nxt_winCnt = '0;
        if (pulseCnt_ff >= 32'(FAULT_PULSE_CYC - 1)) begin
          nxt_state = WD_FIRST;
        end else begin
          nxt_pulseCnt = pulseCnt_ff + 32'h1;
        end
      end
      default: begin
        // The fourth code of the state register is never entered; recover to first-kick.
        nxt_state = WD_FIRST;
        nxt_winCnt = '0;
      end
    endcase
    if (sysRstN_ff && !sysRstPrev_ff) begin
      nxt_state = WD_FIRST;
      nxt_winCnt = '0;
    end
    if (!mrN) begin
      nxt_state = WD_FIRST;
      nxt_winCnt = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= WD_FIRST;
      winCnt_ff <= '0;
      pulseCnt_ff <= 32'h0;
      sysRstPrev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      winCnt_ff <= nxt_winCnt;
      pulseCnt_ff <= nxt_pulseCnt;
      sysRstPrev_ff <= sysRstN_ff;
    end
  end
  assign watchdog_fault_pulse_n = (state_ff != WD_FAULT);
endmodule

// *** pkg/wdog_supervisor_map.svh ***
// Timing constants and option table for the windowed watchdog supervisor.
// Assumes a 20 MHz clock; all counts are derived from times in their own units.
`ifndef WDOG_SUPERVISOR_MAP_SVH
`define WDOG_SUPERVISOR_MAP_SVH

`define CLK_HZ 20000000
`define CLK_PERIOD_NS 50
// Reset stretch, least time, in ms.
`define RESET_STRETCH_MS 100
`define RESET_STRETCH_CYC ((`RESET_STRETCH_MS * (`CLK_HZ / 1000)))
// Fault pulse width, nominal, in us.
`define FAULT_PULSE_US 1000
`define FAULT_PULSE_CYC ((`FAULT_PULSE_US * (`CLK_HZ / 1000000)))
// Least kick pulse width, in ns; rounded up to cycles.
`define KICK_MIN_NS 300
`define KICK_MIN_CYC ((`KICK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Option table, times in us: fast maximum, slow minimum.
`define FAST_US_A 1500
`define FAST_US_B 15000
`define FAST_US_C 15000
`define FAST_US_D 15000
`define FAST_US_E 15000
`define FAST_US_F 23000
`define FAST_US_G 39000
`define FAST_US_H 719000
`define SLOW_US_A 10000
`define SLOW_US_B 100000
`define SLOW_US_C 300000
`define SLOW_US_D 10000000
`define SLOW_US_E 60000000
`define SLOW_US_F 47000
`define SLOW_US_G 82000
`define SLOW_US_H 1300000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define WIN_CNT_W 31

`endif

// *** pkg/wdog_supervisor_pkg.sv ***
// Types for the windowed watchdog supervisor.
// Assumes the map header supplies the counter width.
`include "wdog_supervisor_map.svh"
package wdog_supervisor_pkg;
  typedef logic [`WIN_CNT_W-1:0] win_cnt_t;
  typedef logic [2:0] option_t;
  typedef struct packed {
    win_cnt_t fastCyc;
    win_cnt_t slowCyc;
  } window_s;
  typedef enum logic [1:0] {WD_FIRST, WD_ARMED, WD_FAULT} wd_state_e;
endpackage

// *** tb/wdog_supervisor_checker.sv ***
// Port checker for the watchdog supervisor.
// Assumes window option A; counts come from the bound instance.
`timescale 1ns/100ps
`include "wdog_supervisor_map.svh"
module wdog_supervisor_checker #(parameter int RESET_STRETCH_CYC = 50,
  parameter int FAULT_PULSE_CYC = 20, parameter int CYC_PER_US = 1) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Pins.
  input wire logic supplyLow,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic systemReset_n,
  input wire logic watchdog_fault_pulse_n
);
  // Margins cover the two-flop input synchronisers.
  localparam int FAST = `FAST_US_A * CYC_PER_US - 2;
  localparam int SLOW = `SLOW_US_A * CYC_PER_US + 8;
  int quiet_ff, low_ff, idle_ff;
  logic seen_ff, armed_ff, kick_ff, fall, ok;
  assign fall = kick_ff && !watchdog_kick_in;
  assign ok = systemReset_n && watchdog_fault_pulse_n && manual_reset_n;
  always_ff @(posedge clock) begin
    kick_ff <= watchdog_kick_in;
    quiet_ff <= (rst || supplyLow || !manual_reset_n) ? 0 : quiet_ff + 1;
    low_ff <= (rst || watchdog_fault_pulse_n) ? 0 : low_ff + 1;
    idle_ff <= fall ? 0 : idle_ff + 1;
    seen_ff <= !fall && (seen_ff || !watchdog_fault_pulse_n || !systemReset_n);
    armed_ff <= fall ? ok : armed_ff && ok;
  end
  a_supply_reset: assert property (@(posedge clock) disable iff (rst)
    supplyLow [*3] |=> !systemReset_n) else $error("no reset on supply");
  a_manual_reset: assert property (@(posedge clock) disable iff (rst)
    !manual_reset_n [*3] |=> !systemReset_n) else $error("no manual reset");
  a_stretch_long: assert property (@(posedge clock) disable iff (rst)
    $rose(systemReset_n) |-> quiet_ff >= RESET_STRETCH_CYC) else $error("stretch short");
  a_pulse_width: assert property (@(posedge clock) disable iff (rst)
    $rose(watchdog_fault_pulse_n) |-> low_ff == FAULT_PULSE_CYC) else $error("pulse width");
  a_manual_frees_pulse: assert property (@(posedge clock) disable iff (rst)
    !manual_reset_n [*3] |=> watchdog_fault_pulse_n) else $error("pulse during manual");
  a_slow_fault: assert property (@(posedge clock) disable iff (rst)
    idle_ff == SLOW |-> seen_ff) else $error("no slow fault");
  a_fast_fault: assert property (@(posedge clock) disable iff (rst)
    fall && armed_ff && ok && idle_ff < FAST |-> ##[1:5] !watchdog_fault_pulse_n)
    else $error("no fast fault");
  a_first_kick_free: assert property (@(posedge clock) disable iff (rst)
    fall && !armed_ff && ok && idle_ff > 8 |=> watchdog_fault_pulse_n [*4])
    else $error("first kick faulted");
endmodule
bind windowed_watchdog_supervisor wdog_supervisor_checker #(
  .RESET_STRETCH_CYC(RESET_STRETCH_CYC), .FAULT_PULSE_CYC(FAULT_PULSE_CYC),
  .CYC_PER_US(CYC_PER_US)) chk (.clock(clock), .rst(rst), .supplyLow(supplyLow),
  .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
  .systemReset_n(systemReset_n), .watchdog_fault_pulse_n(watchdog_fault_pulse_n));

// *** tb/kick_processor_model.sv ***
// Processor model that kicks the watchdog every gap+1 cycles while enabled.
// Assumes the bench retunes gap just after a kick.
`timescale 1ns/100ps
module kick_processor_model (
  // Clock and control.
  input wire logic clock,
  input wire logic enable,
  input wire logic [15:0] gap,
  // Kick out.
  output logic kick
);
  logic [15:0] count_ff = 16'h0;
  initial kick = 1'b1;
  // Low for nine cycles, above the least width of six.
  always @(negedge clock) begin
    count_ff <= (enable && count_ff != gap) ? count_ff + 16'h1 : 16'h0;
    kick <= !(enable && count_ff == gap) && (kick || count_ff >= 16'h8 || !enable);
  end
endmodule

// *** tb/windowed_watchdog_supervisor_tb.sv ***
// Bench for the watchdog supervisor driven by a kicking processor model.
// Assumes option A with shortened stretch and pulse counts.
`timescale 1ns/100ps
module windowed_watchdog_supervisor_tb;
  logic clock = 1'b0, rst = 1'b1, supplyLow = 1'b0, manual_reset_n = 1'b1, enable = 1'b0;
  logic [15:0] gap = 16'h7d0, seed = 16'h10;
  logic kick, sysRstN, faultN;
  logic [1:0] prev = 2'h1, want;
  logic [1:0] expQ[$];
  int bad_count = 0, tests_run = 0, cycles = 0;
  // Option A is the default window, so only the shortened counts are overridden.
  windowed_watchdog_supervisor #(.RESET_STRETCH_CYC(50),
    .FAULT_PULSE_CYC(20), .CYC_PER_US(1)) dut (.clock(clock), .rst(rst),
    .supplyLow(supplyLow), .manual_reset_n(manual_reset_n), .watchdog_kick_in(kick),
    .systemReset_n(sysRstN), .watchdog_fault_pulse_n(faultN));
  kick_processor_model cpu (.clock(clock), .enable(enable), .gap(gap), .kick(kick));
  initial begin
    forever #25 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic kicks(input int n);
    repeat (n) @(negedge kick);
    @(negedge clock);
  endtask
  // Each change of the output pair is held against the oldest note.
  always @(negedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      report_and_stop();
    end
    if (!rst && {sysRstN, faultN} !== prev) begin
      prev = {sysRstN, faultN};
      tests_run++;
      want = expQ.size() ? expQ.pop_front() : 2'h0;
      if (want !== prev) begin
        bad_count++;
        $display("BAD %0t exp %h got %h", $time, want, prev);
      end
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    expQ.push_back(2'h3);
    repeat (100) @(negedge clock);
    enable = 1'b1;
    kicks(2);
    gap = 16'h64;
    expQ.push_back(2'h2);
    expQ.push_back(2'h3);
    kicks(2);
    gap = 16'h7d0;
    kicks(1);
    enable = 1'b0;
    expQ.push_back(2'h2);
    expQ.push_back(2'h3);
    repeat (10100) @(negedge clock);
    enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      kicks(1);
      expQ.push_back(2'h1);
      expQ.push_back(2'h3);
      supplyLow = (i == 0);
      manual_reset_n = (i == 0);
      repeat (10) @(negedge clock);
      supplyLow = 1'b0;
      manual_reset_n = 1'b1;
    end
    for (int i = 0; i < 6; i++) begin
      kicks(1);
      seed = lfsr(seed);
      gap = 16'h640 + seed % 16'h1b58;
    end
    kicks(1);
    tests_run++;
    if (expQ.size() != 0) begin
      bad_count++;
      $display("BAD %0t exp %h got %h", $time, 0, expQ.size());
    end
    report_and_stop();
  end
endmodule
